// file: rtl/fepwm_top.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "fepwm_cfg.svh"
module fepwm_top
    import fepwm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             pwm_a,
    output logic             pwm_b,
    output logic      [3:0]  pwm_a_fall_phase,
    output logic      [3:0]  pwm_b_rise_phase,
    output logic      [3:0]  pwm_b_fall_phase,
    output logic             fine_edge_multi_output_enable,
    output logic             phase_clock_set_enable,
    output logic      [1:0]  fine_edge_step_select,
    output logic             sample_trigger,
    output logic             general_purpose_converter_start,
    output logic             period_irq_event,
    output logic             irq
);

    fepwm_ctrl_t  ctrl_reg;
    logic [13:0]  period_reg;
    logic [17:0]  event_reg [0:3];
    logic [11:0]  sample_reg;
    logic [1:0]   status_reg;
    logic [1:0]   mask_reg;
    logic [13:0]  cnt_reg;
    logic [11:0]  next_pos_reg;
    logic [3:0]   left_reg;
    logic         sample_trigger_reg;
    logic         pwm_a_reg;
    logic         pwm_b_reg;
    logic         resync_reg;
    logic [31:0]  prdata_reg;

    logic         wr_en;
    logic         addr_hit;
    logic [31:0]  rdata;
    logic [31:0]  ctrl_word;
    logic [13:0]  period_m1;
    logic         period_end;
    logic         ctl_tick;
    logic         trig_hit;
    logic [11:0]  period_ctl;
    logic [11:0]  sub_raw;
    logic [11:0]  sub;
    logic [12:0]  pos_sum;
    logic [11:0]  pos_wrap;
    logic [3:0]   os_total;
    logic         fine_on;
    logic         div_pulse;
    logic [7:0]   div_limit;
    logic [1:0]   status_set;
    logic [1:0]   status_clr;
    fepwm_edge_t  edge_arr [0:3];

    // Zero wait states: read data is latched in the setup phase
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata  = prdata_reg;
    assign wr_en   = psel && penable && pwrite && addr_hit;

    assign ctrl_word = {11'h000, ctrl_reg.adc_route, ctrl_reg.irq_div, 6'h00, ctrl_reg.os,
                        2'h0, ctrl_reg.step, 1'b0, ctrl_reg.phase_en, ctrl_reg.multi_en,
                        ctrl_reg.run};

    always_comb begin
        addr_hit = 1'b1;
        rdata    = 32'h0000_0000;
        case (paddr)
            `FEPWM_OFF_CTRL:   rdata = ctrl_word;
            `FEPWM_OFF_PERIOD: rdata = {18'h00000, period_reg};
            `FEPWM_OFF_EV1:    rdata = {14'h0000, event_reg[0]};
            `FEPWM_OFF_EV2:    rdata = {14'h0000, event_reg[1]};
            `FEPWM_OFF_EV3:    rdata = {14'h0000, event_reg[2]};
            `FEPWM_OFF_EV4:    rdata = {14'h0000, event_reg[3]};
            `FEPWM_OFF_SAMPLE: rdata = {20'h00000, sample_reg};
            `FEPWM_OFF_STATUS: rdata = {30'h0000_0000, status_reg};
            `FEPWM_OFF_MASK:   rdata = {30'h0000_0000, mask_reg};
            `FEPWM_OFF_COUNT:  rdata = {18'h00000, cnt_reg};
            default:           addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_reg <= rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `FEPWM_RST_CTRL;
        end else if (wr_en && paddr == `FEPWM_OFF_CTRL) begin
            ctrl_reg.run       <= pwdata[`FEPWM_CTRL_RUN];
            ctrl_reg.multi_en  <= pwdata[`FEPWM_CTRL_MULTI];
            ctrl_reg.phase_en  <= pwdata[`FEPWM_CTRL_PHASE];
            ctrl_reg.step      <= pwdata[`FEPWM_CTRL_STEP +: 2];
            ctrl_reg.os        <= pwdata[`FEPWM_CTRL_OS +: 2];
            ctrl_reg.irq_div   <= pwdata[`FEPWM_CTRL_DIV +: 4];
            ctrl_reg.adc_route <= pwdata[`FEPWM_CTRL_ROUTE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_reg <= `FEPWM_RST_PERIOD;
            sample_reg <= `FEPWM_RST_SAMPLE;
            mask_reg   <= `FEPWM_RST_MASK;
        end else if (wr_en) begin
            if (paddr == `FEPWM_OFF_PERIOD) begin
                period_reg <= pwdata[13:0];
            end
            if (paddr == `FEPWM_OFF_SAMPLE) begin
                sample_reg <= pwdata[11:0];
            end
            if (paddr == `FEPWM_OFF_MASK) begin
                mask_reg <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                event_reg[i] <= `FEPWM_RST_EVENT;
            end
        end else if (wr_en) begin
            for (int i = 0; i < 4; i++) begin
                if (paddr == 8'(`FEPWM_OFF_EV1 + 8'(i * 4))) begin
                    event_reg[i] <= pwdata[17:0];
                end
            end
        end
    end

    // Period counter in fast-clock units
    assign period_m1  = (period_reg == 14'h0000) ? 14'h0000 : 14'(period_reg - 14'h0001);
    assign period_end = ctrl_reg.run && (cnt_reg >= period_m1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 14'h0000;
        end else if (!ctrl_reg.run || period_end) begin
            cnt_reg <= 14'h0000;
        end else begin
            cnt_reg <= 14'(cnt_reg + 14'h0001);
        end
    end

    // Quarter-rate control tick, realigned to every period start
    assign ctl_tick   = ctrl_reg.run && (cnt_reg[1:0] == 2'b00);
    assign period_ctl = period_reg[13:2];
    assign trig_hit   = ctl_tick && (cnt_reg[13:2] == next_pos_reg);

    assign os_total = 4'(4'h1 << ctrl_reg.os);
    assign sub_raw  = period_ctl >> ctrl_reg.os;
    assign sub      = (sub_raw == 12'h000) ? 12'h001 : sub_raw;
    assign pos_sum  = {1'b0, next_pos_reg} + {1'b0, sub};
    // Positions past the period end wrap into the next period
    assign pos_wrap = (pos_sum >= {1'b0, period_ctl}) ? 12'(pos_sum - {1'b0, period_ctl})
                                                      : pos_sum[11:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resync_reg <= 1'b0;
        end else begin
            resync_reg <= wr_en && (paddr == `FEPWM_OFF_CTRL || paddr == `FEPWM_OFF_SAMPLE ||
                                    paddr == `FEPWM_OFF_PERIOD);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_pos_reg <= `FEPWM_RST_SAMPLE;
            left_reg     <= 4'h1;
        end else if (!ctrl_reg.run || resync_reg) begin
            next_pos_reg <= sample_reg;
            left_reg     <= os_total;
        end else if (trig_hit) begin
            if (left_reg <= 4'h1) begin
                next_pos_reg <= sample_reg;
                left_reg     <= os_total;
            end else begin
                next_pos_reg <= pos_wrap;
                left_reg     <= 4'(left_reg - 4'h1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_trigger_reg <= 1'b0;
        end else begin
            sample_trigger_reg <= trig_hit;
        end
    end

    // Fine phases only when both the multi-output and phase-clock enables are set
    assign fine_on = ctrl_reg.multi_en && ctrl_reg.phase_en;

    generate
        for (genvar g = 0; g < 4; g++) begin : g_edge
            fepwm_edge #(
                .FINE (g != 0)
            ) u_edge (
                .pclk    (pclk),
                .presetn (presetn),
                .en      (ctrl_reg.run),
                .cnt     (cnt_reg),
                .value   (event_reg[g]),
                .fine_on (fine_on),
                .step    (ctrl_reg.step),
                .edge_o  (edge_arr[g])
            );
        end
    endgenerate

    // Falling edge wins a tie so equal events give a zero-width pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_a_reg <= 1'b0;
        end else if (!ctrl_reg.run || edge_arr[1].hit) begin
            pwm_a_reg <= 1'b0;
        end else if (edge_arr[0].hit) begin
            pwm_a_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_b_reg <= 1'b0;
        end else if (!ctrl_reg.run || edge_arr[3].hit) begin
            pwm_b_reg <= 1'b0;
        end else if (edge_arr[2].hit) begin
            pwm_b_reg <= 1'b1;
        end
    end

    fepwm_irqdiv u_irqdiv (
        .pclk       (pclk),
        .presetn    (presetn),
        .period_end (period_end),
        .setting    (ctrl_reg.irq_div),
        .limit      (div_limit),
        .pulse      (div_pulse)
    );

    // Set wins over a simultaneous write-one clear
    assign status_set = {sample_trigger_reg, div_pulse};
    assign status_clr = (wr_en && paddr == `FEPWM_OFF_STATUS) ? pwdata[1:0] : 2'b00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 2'b00;
        end else begin
            status_reg <= (status_reg & ~status_clr) | status_set;
        end
    end

    assign irq                             = |(status_reg & mask_reg);
    assign period_irq_event                = div_pulse;
    assign general_purpose_converter_start = div_pulse && ctrl_reg.adc_route;
    assign sample_trigger                  = sample_trigger_reg;
    assign pwm_a                           = pwm_a_reg;
    assign pwm_b                           = pwm_b_reg;
    assign pwm_a_fall_phase                = edge_arr[1].phase;
    assign pwm_b_rise_phase                = edge_arr[2].phase;
    assign pwm_b_fall_phase                = edge_arr[3].phase;
    assign fine_edge_multi_output_enable   = ctrl_reg.multi_en;
    assign phase_clock_set_enable          = ctrl_reg.phase_en;
    assign fine_edge_step_select           = ctrl_reg.step;

    // Helper state for the checks below
    logic [3:0] tc_reg;
    logic       clean_reg;
    logic [8:0] pe_cnt_reg;
    logic       div_clean_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_reg        <= 4'h0;
            clean_reg     <= 1'b0;
            pe_cnt_reg    <= 9'h000;
            div_clean_reg <= 1'b0;
        end else begin
            tc_reg <= period_end ? 4'h0 : 4'(tc_reg + {3'h0, trig_hit});
            if (resync_reg || !ctrl_reg.run) begin
                clean_reg <= 1'b0;
            end else if (period_end) begin
                clean_reg <= 1'b1;
            end
            if (div_pulse) begin
                pe_cnt_reg <= {8'h00, period_end};
            end else if (period_end) begin
                pe_cnt_reg <= 9'(pe_cnt_reg + 9'h001);
            end
            if (wr_en && paddr == `FEPWM_OFF_CTRL) begin
                div_clean_reg <= 1'b0;
            end else if (div_pulse) begin
                div_clean_reg <= 1'b1;
            end
        end
    end

    a_sample_pos: assert property (@(posedge pclk) disable iff (!presetn)
        sample_trigger |-> $past(cnt_reg[1:0]) == 2'b00
                        && $past(cnt_reg[13:2]) == $past(next_pos_reg))
        else $error("sample trigger off its programmed position");

    a_trig_count: assert property (@(posedge pclk) disable iff (!presetn)
        (period_end && clean_reg && !resync_reg) |-> (tc_reg + {3'h0, trig_hit}) <= os_total)
        else $error("too many sample triggers in one period");

    a_single_trig: assert property (@(posedge pclk) disable iff (!presetn)
        (period_end && clean_reg && !resync_reg && ctrl_reg.os == 2'b00)
        |-> (tc_reg + {3'h0, trig_hit}) <= 4'h1)
        else $error("more than one trigger without oversampling");

    a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
        div_pulse |=> status_reg[`FEPWM_ST_DIV])
        else $error("period event lost from status");

    a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (status_reg[`FEPWM_ST_SAMPLE] && status_clr[`FEPWM_ST_SAMPLE] == 1'b0)
        |=> status_reg[`FEPWM_ST_SAMPLE])
        else $error("sample status dropped without clear");

    a_div_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (div_pulse && div_clean_reg && period_m1 >= 14'h0002)
        |-> pe_cnt_reg == 9'({1'b0, div_limit} + 9'h001))
        else $error("interrupt spacing differs from divide count");

    a_period_src: assert property (@(posedge pclk) disable iff (!presetn)
        div_pulse |-> $past(period_end) && $past(ctrl_reg.irq_div) != 4'h0)
        else $error("interrupt without period boundary");

    a_route_gate: assert property (@(posedge pclk) disable iff (!presetn)
        general_purpose_converter_start |-> $past(period_end) && ctrl_reg.adc_route)
        else $error("converter start not from period interrupt");

    a_pwm_fall: assert property (@(posedge pclk) disable iff (!presetn)
        edge_arr[1].hit |=> !pwm_a_reg)
        else $error("output A stayed high after falling event");

    a_counter_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        period_end |=> cnt_reg == 14'h0000)
        else $error("counter did not restart at period end");

endmodule

// file: common/fepwm_cfg.svh
`ifndef FEPWM_CFG_SVH
`define FEPWM_CFG_SVH

`define FEPWM_OFF_CTRL      8'h00
`define FEPWM_OFF_PERIOD    8'h04
`define FEPWM_OFF_EV1       8'h08
`define FEPWM_OFF_EV2       8'h0C
`define FEPWM_OFF_EV3       8'h10
`define FEPWM_OFF_EV4       8'h14
`define FEPWM_OFF_SAMPLE    8'h18
`define FEPWM_OFF_STATUS    8'h1C
`define FEPWM_OFF_MASK      8'h20
`define FEPWM_OFF_COUNT     8'h24

`define FEPWM_CTRL_RUN      0
`define FEPWM_CTRL_MULTI    1
`define FEPWM_CTRL_PHASE    2
`define FEPWM_CTRL_STEP     4
`define FEPWM_CTRL_OS       8
`define FEPWM_CTRL_DIV      16
`define FEPWM_CTRL_ROUTE    20

`define FEPWM_ST_DIV        0
`define FEPWM_ST_SAMPLE     1

`define FEPWM_RST_CTRL      12'h000
`define FEPWM_RST_PERIOD    14'h0064
`define FEPWM_RST_EVENT     18'h00000
`define FEPWM_RST_SAMPLE    12'h000
`define FEPWM_RST_MASK      2'h0

`define FEPWM_FINE_PHASES   16
`define FEPWM_CLK_PERIOD_PS 10000
`define FEPWM_FINE_STEP_PS  ((`FEPWM_CLK_PERIOD_PS) / (`FEPWM_FINE_PHASES))
`define FEPWM_CTL_RATIO     4

`define FEPWM_DIVC_1        8'h00
`define FEPWM_DIVC_2        8'h01
`define FEPWM_DIVC_3        8'h03
`define FEPWM_DIVC_4        8'h07
`define FEPWM_DIVC_5        8'h0F
`define FEPWM_DIVC_6        8'h1F
`define FEPWM_DIVC_7        8'h2F
`define FEPWM_DIVC_8        8'h3F
`define FEPWM_DIVC_9        8'h4F
`define FEPWM_DIVC_10       8'h5F
`define FEPWM_DIVC_11       8'h7F
`define FEPWM_DIVC_12       8'h9F
`define FEPWM_DIVC_13       8'hBF
`define FEPWM_DIVC_14       8'hDF
`define FEPWM_DIVC_15       8'hFF

`endif

// file: common/fepwm_pkg.sv
package fepwm_pkg;

    typedef struct packed {
        logic       adc_route;
        logic [3:0] irq_div;
        logic [1:0] os;
        logic [1:0] step;
        logic       phase_en;
        logic       multi_en;
        logic       run;
    } fepwm_ctrl_t;

    typedef struct packed {
        logic       hit;
        logic [3:0] phase;
    } fepwm_edge_t;

endpackage

// file: rtl/fepwm_edge.sv
`timescale 1ns/1ps
module fepwm_edge
    import fepwm_pkg::*;
#(
    parameter bit FINE = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        en,
    input  wire logic [13:0] cnt,
    input  wire logic [17:0] value,
    input  wire logic        fine_on,
    input  wire logic [1:0]  step,
    output fepwm_edge_t      edge_o
);

    logic [3:0] step_mask;

    // Coarser steps drop low fine bits; step 0 keeps all sixteen phases
    assign step_mask = 4'(4'hF << step);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_o <= '0;
        end else begin
            edge_o.hit <= en && (cnt == value[17:4]);
            if (FINE && fine_on) begin
                edge_o.phase <= value[3:0] & step_mask;
            end else begin
                edge_o.phase <= 4'h0;
            end
        end
    end

    a_fine_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (edge_o.phase != 4'h0) |-> $past(fine_on) && FINE)
        else $error("fine phase set while fine section off");

    a_coarse_hit: assert property (@(posedge pclk) disable iff (!presetn)
        edge_o.hit |-> $past(cnt) == $past(value[17:4]))
        else $error("edge hit without coarse match");

endmodule

// file: rtl/fepwm_irqdiv.sv
`timescale 1ns/1ps
`include "fepwm_cfg.svh"
module fepwm_irqdiv
    import fepwm_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       period_end,
    input  wire logic [3:0] setting,
    output logic      [7:0] limit,
    output logic            pulse
);

    logic [7:0] cnt_reg;

    always_comb begin
        case (setting)
            4'h1:    limit = `FEPWM_DIVC_1;
            4'h2:    limit = `FEPWM_DIVC_2;
            4'h3:    limit = `FEPWM_DIVC_3;
            4'h4:    limit = `FEPWM_DIVC_4;
            4'h5:    limit = `FEPWM_DIVC_5;
            4'h6:    limit = `FEPWM_DIVC_6;
            4'h7:    limit = `FEPWM_DIVC_7;
            4'h8:    limit = `FEPWM_DIVC_8;
            4'h9:    limit = `FEPWM_DIVC_9;
            4'hA:    limit = `FEPWM_DIVC_10;
            4'hB:    limit = `FEPWM_DIVC_11;
            4'hC:    limit = `FEPWM_DIVC_12;
            4'hD:    limit = `FEPWM_DIVC_13;
            4'hE:    limit = `FEPWM_DIVC_14;
            4'hF:    limit = `FEPWM_DIVC_15;
            default: limit = 8'h00;
        endcase
    end

    // Setting 0 parks the divider; >= guards a limit lowered mid-count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else if (setting == 4'h0) begin
            cnt_reg <= 8'h00;
        end else if (period_end) begin
            if (cnt_reg >= limit) begin
                cnt_reg <= 8'h00;
            end else begin
                cnt_reg <= 8'(cnt_reg + 8'h01);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse <= 1'b0;
        end else begin
            pulse <= (setting != 4'h0) && period_end && (cnt_reg >= limit);
        end
    end

    a_div_restart: assert property (@(posedge pclk) disable iff (!presetn)
        pulse |-> cnt_reg == 8'h00)
        else $error("divider did not restart after pulse");

endmodule

// file: tb/fepwm_stage_model.sv
`timescale 1ns/1ps
module fepwm_stage_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwm_a,
    input wire logic pwm_b,
    input wire logic sample_trigger
);
    int   conv_count;
    int   rise_count;
    int   b_high;
    logic a_last;
    // Each trigger starts one conversion; B is counted by level, A by rising edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_count <= 0;
            rise_count <= 0;
            b_high     <= 0;
            a_last     <= 1'b0;
        end else begin
            a_last <= pwm_a;
            if (sample_trigger === 1'b1) conv_count <= conv_count + 1;
            if (pwm_b === 1'b1) b_high <= b_high + 1;
            if (pwm_a === 1'b1 && a_last === 1'b0) rise_count <= rise_count + 1;
        end
    end
endmodule

// file: tb/test_fine_edge_pwm_sampling_irq.sv
`timescale 1ns/1ps
`include "fepwm_cfg.svh"
module test_fine_edge_pwm_sampling_irq;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, pwm_a, pwm_b, ms, ps, st, gs, pe, irq, er;
    logic [3:0]  af, br, bf;
    logic [1:0]  ss;
    int          n_errors = 0, n_compared = 0, c0, c1, ni, ng;
    fepwm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_a(pwm_a), .pwm_b(pwm_b), .pwm_a_fall_phase(af),
        .pwm_b_rise_phase(br), .pwm_b_fall_phase(bf), .fine_edge_multi_output_enable(ms),
        .phase_clock_set_enable(ps), .fine_edge_step_select(ss), .sample_trigger(st),
        .general_purpose_converter_start(gs), .period_irq_event(pe), .irq(irq));
    fepwm_stage_model m (.pclk(pclk), .presetn(presetn), .pwm_a(pwm_a), .pwm_b(pwm_b),
        .sample_trigger(st));
    initial forever #5 pclk = ~pclk;
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; entered just after a rising edge, waits for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int g;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        g = 0;
        do begin
            @(posedge pclk);
            g++;
        end while (pready !== 1'b1 && g < 50);
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task t_reset_map;
        apb(0, `FEPWM_OFF_CTRL, 0);
        chk("ctrl", rd, 0);
        apb(0, `FEPWM_OFF_PERIOD, 0);
        chk("period", rd, 32'h64);
        chk("no slverr", er, 0);
        apb(0, `FEPWM_OFF_STATUS, 0);
        chk("status", rd, 0);
        apb(0, 8'h40, 0);
        chk("unmapped", rd, 0);
        chk("slverr", er, 1);
        $display("test reset_map done");
    endtask
    // PERIOD 32 gives 8 quarter-rate slots; two whole periods are counted
    task t_oversample;
        for (int os = 0; os < 4; os++) begin
            apb(1, `FEPWM_OFF_PERIOD, 32);
            apb(1, `FEPWM_OFF_SAMPLE, 1);
            apb(1, `FEPWM_OFF_CTRL, (os << `FEPWM_CTRL_OS) | 1);
            repeat (40) @(posedge pclk);
            c0 = m.conv_count;
            repeat (64) @(posedge pclk);
            chk("triggers", m.conv_count - c0, 2 << os);
        end
        $display("test oversample done");
    endtask
    // PERIOD 8 over 128 cycles gives 16 periods, split by divide limit + 1 (1, 2, 4); last pass unrouted
    task t_divider;
        for (int s = 1; s < 4; s++) begin
            apb(1, `FEPWM_OFF_PERIOD, 8);
            apb(1, `FEPWM_OFF_CTRL,
                (s << `FEPWM_CTRL_DIV) | (s == 3 ? 0 : 1 << `FEPWM_CTRL_ROUTE) | 1);
            repeat (64) @(posedge pclk);
            ni = 0;
            ng = 0;
            // Read at the edge, so each sample is the cycle just ended
            repeat (128) begin
                @(posedge pclk);
                ni += pe;
                ng += gs;
            end
            chk("irq events", ni, 16 >> (s - 1));
            chk("adc starts", ng, s == 3 ? 0 : 16 >> (s - 1));
        end
        apb(1, `FEPWM_OFF_CTRL, 0);
        apb(1, `FEPWM_OFF_MASK, 1);
        chk("irq masked in", irq, 1);
        apb(1, `FEPWM_OFF_MASK, 0);
        chk("irq masked out", irq, 0);
        apb(1, `FEPWM_OFF_MASK, 1);
        apb(1, `FEPWM_OFF_STATUS, 1);
        chk("irq cleared", irq, 0);
        apb(0, `FEPWM_OFF_STATUS, 0);
        chk("status w1c", rd, 2);
        apb(1, `FEPWM_OFF_MASK, 2);
        chk("irq sample", irq, 1);
        $display("test divider done");
    endtask
    // Fine bits only reach the phase outputs with both enables set
    task t_edges;
        apb(1, `FEPWM_OFF_PERIOD, 32);
        apb(1, `FEPWM_OFF_EV1, 2 << 4);
        apb(1, `FEPWM_OFF_EV2, (10 << 4) | 9);
        apb(1, `FEPWM_OFF_EV3, (4 << 4) | 5);
        apb(1, `FEPWM_OFF_EV4, (12 << 4) | 3);
        for (int sp = 0; sp < 3; sp += 2) begin
            apb(1, `FEPWM_OFF_CTRL, (sp << `FEPWM_CTRL_STEP) | 7);
            c0 = m.rise_count;
            c1 = m.b_high;
            // B is high from count 4 to 12: eight cycles in each of two periods
            repeat (64) @(posedge pclk);
            chk("a fall", af, 9 & (15 << sp));
            chk("b rise", br, 5 & (15 << sp));
            chk("b fall", bf, 3 & (15 << sp));
            chk("step out", ss, sp);
            chk("enables", {ms, ps}, 2'b11);
            chk("a pulses", m.rise_count - c0, 2);
            chk("b high", m.b_high - c1, 16);
        end
        apb(1, `FEPWM_OFF_CTRL, 3);
        repeat (2) @(posedge pclk);
        chk("a fall off", af, 0);
        chk("b rise off", br, 0);
        chk("b fall off", bf, 0);
        chk("enables off", {ms, ps}, 2'b10);
        $display("test edges done");
    endtask
    task wrap_up;
        $display("compared %0d mismatched %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_map;
        t_oversample;
        t_divider;
        t_edges;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        wrap_up;
    end
endmodule
